// ==== hdl/aics_top.sv ====
// bus slave, command decoder and power control of the converter
`timescale 1ns/1ps
module aics_top (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clkEn,
    // bus pins
    input  wire logic       sclIn,
    output logic            sclOut,
    output logic            sclOeN,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOeN,
    // address select pins
    input  wire logic       addrPinHigh,
    input  wire logic       addrPinLow,
    // analog side
    input  wire logic       cmpOut,
    output logic [7:0]      dacCode,
    output logic            inputTypeSel,
    output logic [2:0]      channelSel,
    output logic            converterOn,
    output logic            referenceOn,
    output logic            internalClkOn
);
    // ****************************************
    // types and state
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WRITE_ACK,
        ST_READ,
        ST_READ_ACK
    } aics_state_t;

    aics_state_t                  state_r;
    aics_state_t                  state_nxt;
    logic [aics_pkg::CNT_W-1:0]   bitCnt_r;
    logic [aics_pkg::CNT_W-1:0]   bitCnt_nxt;
    logic [7:0]                   rxShift_r;
    logic [7:0]                   rxShift_nxt;
    logic [7:0]                   txShift_r;
    logic [7:0]                   txShift_nxt;
    logic [7:0]                   cmdReg_r;
    logic [7:0]                   cmdReg_nxt;
    logic                         readDir_r;
    logic                         readDir_nxt;
    logic                         hsMode_r;
    logic                         hsMode_nxt;
    logic                         stretch_r;
    logic                         stretch_nxt;
    logic                         earlyPwr_r;
    logic                         earlyPwr_nxt;
    logic                         masterAck_r;
    logic                         masterAck_nxt;
    logic                         convStart_nxt;
    logic                         pinsCaught_r;
    logic [1:0]                   addrLow_r;
    logic                         muxType_r;
    logic                         muxType_nxt;
    logic [2:0]                   muxChan_r;
    logic [2:0]                   muxChan_nxt;
    logic [4:0]                   holdCnt_r;
    logic                         sdaDrive_r;
    logic                         sclPrev_r;
    logic                         sdaPrev_r;
    logic                         stretchTail_r;

    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int NSYNC = 5;
    wire  [NSYNC-1:0] rawIn = {cmpOut, addrPinHigh, addrPinLow, sdaIn, sclIn};
    logic [NSYNC-1:0] syncA_r;
    logic [NSYNC-1:0] syncB_r;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    syncA_r[gi] <= 1'b1;
                    syncB_r[gi] <= 1'b1;
                end else if (clkEn) begin
                    syncA_r[gi] <= rawIn[gi];
                    syncB_r[gi] <= syncA_r[gi];
                end
            end
        end
    endgenerate

    wire sclS   = syncB_r[0];
    wire sdaS   = syncB_r[1];
    wire pinLow = syncB_r[2];
    wire pinHi  = syncB_r[3];
    wire cmpS   = syncB_r[4];

    // ****************************************
    // bus condition decode
    // ****************************************
    wire sclRise    = sclS & ~sclPrev_r;
    wire sclFall    = ~sclS & sclPrev_r;
    wire startCond  = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
    wire stopCond   = sclS & sclPrev_r & ~sdaPrev_r & sdaS;
    wire byteDone   = (bitCnt_r == 4'(aics_pkg::BYTE_BITS));
    wire [6:0] ownAddr = {aics_pkg::ADDR_FIXED, addrLow_r};
    wire addrMatch  = (rxShift_r[7:1] == ownAddr);
    wire hsCode     = (rxShift_r[7:3] == aics_pkg::HS_CODE_HEAD);
    wire eighthRise = sclRise & (state_r == ST_ADDR) & (bitCnt_r == 4'h7);
    wire [1:0] pwrSel = cmdReg_r[aics_pkg::CMD_PWR_HI:aics_pkg::CMD_PWR_LO];

    // ****************************************
    // sequencer
    // ****************************************
    aics_conv_if #(.W(aics_pkg::RESULT_W)) conv ();

    assign conv.cmpBit = cmpS;

    aics_sar_seq #(
        .W      (aics_pkg::RESULT_W),
        .PERIOD (aics_pkg::SAR_PERIOD_CYCLES)
    ) u_seq (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .conv    (conv.seq)
    );

    // ****************************************
    // frame state machine
    // ****************************************
    always_comb begin
        state_nxt     = state_r;
        bitCnt_nxt    = bitCnt_r;
        rxShift_nxt   = rxShift_r;
        txShift_nxt   = txShift_r;
        cmdReg_nxt    = cmdReg_r;
        readDir_nxt   = readDir_r;
        hsMode_nxt    = hsMode_r;
        stretch_nxt   = stretch_r;
        earlyPwr_nxt  = earlyPwr_r;
        masterAck_nxt = masterAck_r;
        muxType_nxt   = muxType_r;
        muxChan_nxt   = muxChan_r;
        convStart_nxt = 1'b0;
        if (stretch_r && !conv.busy) begin
            stretch_nxt = 1'b0;
            txShift_nxt = conv.trialWord;
        end
        if (startCond) begin
            state_nxt   = ST_ADDR;
            bitCnt_nxt  = '0;
        end else if (stopCond) begin
            state_nxt   = ST_IDLE;
            hsMode_nxt  = 1'b0;
        end else if (sclRise) begin
            case (state_r)
                ST_ADDR, ST_WRITE: begin
                    rxShift_nxt = {rxShift_r[6:0], sdaS};
                    bitCnt_nxt  = bitCnt_r + 4'h1;
                    if (state_r == ST_WRITE && bitCnt_r == 4'h3) begin
                        muxType_nxt  = rxShift_r[2];
                        muxChan_nxt  = {rxShift_r[1:0], sdaS};
                        earlyPwr_nxt = 1'b1;
                    end
                end
                ST_READ: begin
                    bitCnt_nxt = bitCnt_r + 4'h1;
                end
                ST_READ_ACK: begin
                    masterAck_nxt = ~sdaS;
                    bitCnt_nxt    = bitCnt_r + 4'h1;
                end
                ST_ADDR_ACK, ST_WRITE_ACK: begin
                    bitCnt_nxt = bitCnt_r + 4'h1;
                end
                default: begin
                    bitCnt_nxt = bitCnt_r;
                end
            endcase
        end else if (sclFall) begin
            case (state_r)
                ST_ADDR: begin
                    if (byteDone) begin
                        if (addrMatch) begin
                            state_nxt   = ST_ADDR_ACK;
                            readDir_nxt = rxShift_r[0];
                        end else begin
                            state_nxt  = ST_IDLE;
                            hsMode_nxt = hsMode_r | hsCode;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    bitCnt_nxt = '0;
                    if (readDir_r) begin
                        state_nxt   = ST_READ;
                        txShift_nxt = conv.trialWord;
                        stretch_nxt = hsMode_r & conv.busy;
                    end else begin
                        state_nxt = ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (byteDone) begin
                        state_nxt     = ST_WRITE_ACK;
                        cmdReg_nxt    = {rxShift_r[7:2], 2'h0};
                        muxType_nxt   = rxShift_r[aics_pkg::CMD_TYPE_BIT];
                        muxChan_nxt   = rxShift_r[aics_pkg::CMD_CHAN_HI:aics_pkg::CMD_CHAN_LO];
                        convStart_nxt = 1'b1;
                        earlyPwr_nxt  = 1'b0;
                    end
                end
                ST_WRITE_ACK: begin
                    state_nxt  = ST_WRITE;
                    bitCnt_nxt = '0;
                end
                ST_READ: begin
                    if (byteDone) begin
                        state_nxt = ST_READ_ACK;
                    end else begin
                        txShift_nxt = {txShift_r[6:0], 1'b0};
                    end
                end
                ST_READ_ACK: begin
                    bitCnt_nxt = '0;
                    if (masterAck_r) begin
                        state_nxt   = ST_READ;
                        txShift_nxt = conv.trialWord;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // drive wanted on SDA
    // ****************************************
    wire sdaWant = (state_r == ST_ADDR_ACK) | (state_r == ST_WRITE_ACK)
                 | ((state_r == ST_READ) & ~txShift_r[7]);

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r     <= ST_IDLE;
            bitCnt_r    <= '0;
            rxShift_r   <= 8'h00;
            txShift_r   <= 8'h00;
            cmdReg_r    <= aics_pkg::CMD_RESET;
            readDir_r   <= 1'b0;
            hsMode_r    <= 1'b0;
            stretch_r   <= 1'b0;
            earlyPwr_r  <= 1'b0;
            masterAck_r <= 1'b0;
            muxType_r   <= 1'b0;
            muxChan_r   <= 3'h0;
        end else if (clkEn) begin
            state_r     <= state_nxt;
            bitCnt_r    <= bitCnt_nxt;
            rxShift_r   <= rxShift_nxt;
            txShift_r   <= txShift_nxt;
            cmdReg_r    <= cmdReg_nxt;
            readDir_r   <= readDir_nxt;
            hsMode_r    <= hsMode_nxt;
            stretch_r   <= stretch_nxt;
            earlyPwr_r  <= earlyPwr_nxt;
            masterAck_r <= masterAck_nxt;
            muxType_r   <= muxType_nxt;
            muxChan_r   <= muxChan_nxt;
        end
    end

    assign conv.start = convStart_nxt & clkEn;

    // ****************************************
    // edge history and address pin capture
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclPrev_r    <= 1'b1;
            sdaPrev_r    <= 1'b1;
            pinsCaught_r <= 1'b0;
            addrLow_r    <= aics_pkg::ADDR_LOW_RST;
        end else if (clkEn) begin
            sclPrev_r <= sclS;
            sdaPrev_r <= sdaS;
            if (eighthRise && !pinsCaught_r) begin
                addrLow_r    <= {pinHi, pinLow};
                pinsCaught_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // SDA hold after SCL falls
    // ****************************************
    // one cycle after a stretch ends: first data bit reaches SDA on the same clock that SCL is let go
    wire stretchEnd = stretchTail_r & ~stretch_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            holdCnt_r     <= 5'h00;
            sdaDrive_r    <= 1'b0;
            stretchTail_r <= 1'b0;
        end else if (clkEn) begin
            stretchTail_r <= stretch_r;
            if (sclFall) begin
                holdCnt_r <= 5'(aics_pkg::SDA_HOLD_CYCLES);
            end else if (holdCnt_r != 5'h00) begin
                holdCnt_r <= holdCnt_r - 5'h01;
            end
            if (holdCnt_r == 5'h01 || stretchEnd) begin
                sdaDrive_r <= sdaWant;
            end else if (state_r == ST_IDLE) begin
                sdaDrive_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // pin and analog outputs
    // ****************************************
    wire addressing = (state_r != ST_IDLE);
    wire convOnNxt  = conv.busy | addressing | earlyPwr_r
                    | (pwrSel[0] & (pwrSel != aics_pkg::PWR_DOWN_BETWEEN));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sdaOut        <= 1'b0;
            sdaOeN        <= 1'b1;
            sclOut        <= 1'b0;
            sclOeN        <= 1'b1;
            dacCode       <= aics_pkg::RESULT_RST;
            inputTypeSel  <= 1'b0;
            channelSel    <= 3'h0;
            converterOn   <= 1'b0;
            referenceOn   <= 1'b0;
            internalClkOn <= 1'b0;
        end else if (clkEn) begin
            sdaOut        <= 1'b0;
            sdaOeN        <= ~sdaDrive_r;
            sclOut        <= 1'b0;
            sclOeN        <= ~(stretch_r | stretchEnd);
            dacCode       <= conv.trialWord;
            inputTypeSel  <= muxType_r;
            channelSel    <= muxChan_r;
            converterOn   <= convOnNxt;
            referenceOn   <= pwrSel[1];
            internalClkOn <= conv.busy | addressing;
        end
    end
endmodule : aics_top

// ==== hdl/aics_pkg.sv ====
// constants shared by the converter control block
package aics_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int RESULT_W   = 8;
    localparam int BYTE_BITS  = 8;
    localparam int CNT_W      = 4;
    // ****************************************
    // bus address
    // ****************************************
    localparam logic [4:0] ADDR_FIXED   = 5'h12;
    localparam logic [4:0] HS_CODE_HEAD = 5'h01;
    localparam logic [1:0] ADDR_LOW_RST = 2'h0;
    // ****************************************
    // command byte layout
    // ****************************************
    localparam int CMD_TYPE_BIT = 7;
    localparam int CMD_CHAN_HI  = 6;
    localparam int CMD_CHAN_LO  = 4;
    localparam int CMD_PWR_HI   = 3;
    localparam int CMD_PWR_LO   = 2;
    localparam logic [7:0] CMD_RESET  = 8'h00;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [1:0] PWR_DOWN_BETWEEN = 2'h0;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS     = 25;
    localparam int SDA_HOLD_NS       = 300;
    localparam int SDA_HOLD_CYCLES   = (SDA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAR_PERIOD_CYCLES = 6;
endpackage : aics_pkg

// ==== hdl/aics_conv_if.sv ====
// link between the bus controller and the approximation sequencer
`timescale 1ns/1ps
interface aics_conv_if #(parameter int W = 8);
    logic         start;
    logic         cmpBit;
    logic         busy;
    logic [W-1:0] trialWord;
    modport seq  (input start, input cmpBit, output busy, output trialWord);
    modport ctrl (output start, output cmpBit, input busy, input trialWord);
endinterface : aics_conv_if

// ==== hdl/aics_sar_seq.sv ====
// successive approximation sequencer
`timescale 1ns/1ps
module aics_sar_seq #(
    parameter int W      = aics_pkg::RESULT_W,
    parameter int PERIOD = aics_pkg::SAR_PERIOD_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    // converter link
    aics_conv_if.seq  conv
);
    // ****************************************
    // state
    // ****************************************
    logic [W-1:0]         sar_r;
    logic [$clog2(W)-1:0] bitIdx_r;
    logic [7:0]           perCnt_r;
    logic                 busy_r;
    wire                  periodEnd = (perCnt_r == 8'(PERIOD - 1));
    wire                  lastBit   = (bitIdx_r == '0);

    assign conv.busy      = busy_r;
    assign conv.trialWord = sar_r;

    // ****************************************
    // approximation steps
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sar_r    <= '0;
            bitIdx_r <= '0;
            perCnt_r <= 8'h00;
            busy_r   <= 1'b0;
        end else if (clkEn) begin
            if (conv.start) begin
                sar_r    <= {1'b1, {(W-1){1'b0}}};
                bitIdx_r <= ($clog2(W))'(W - 1);
                perCnt_r <= 8'h00;
                busy_r   <= 1'b1;
            end else if (busy_r) begin
                perCnt_r <= periodEnd ? 8'h00 : perCnt_r + 8'h01;
                if (periodEnd) begin
                    sar_r[bitIdx_r] <= conv.cmpBit;
                    if (!lastBit) begin
                        sar_r[bitIdx_r - 1'b1] <= 1'b1;
                        bitIdx_r <= bitIdx_r - 1'b1;
                    end else begin
                        busy_r <= 1'b0;
                    end
                end
            end
        end
    end
endmodule : aics_sar_seq

// ==== sim/aics_sva.sv ====
// assertions on the converter control top ports
`timescale 1ns/1ps
module aics_sva (
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // bus pins
    input wire logic       sclIn,
    input wire logic       sclOut,
    input wire logic       sclOeN,
    input wire logic       sdaOut,
    input wire logic       sdaOeN,
    // converter side
    input wire logic [7:0] dacCode,
    input wire logic       converterOn,
    input wire logic       referenceOn,
    input wire logic       internalClkOn
);
    // cycles that scl has been low, saturating
    logic [3:0] sclLow_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclLow_r <= 4'h0;
        end else if (sclIn) begin
            sclLow_r <= 4'h0;
        end else if (sclLow_r != 4'hF) begin
            sclLow_r <= sclLow_r + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_sda_hold; $fell(sdaOeN) |-> sclLow_r >= 4'hC; endproperty
    a_sda_hold: assert property (p_sda_hold)
        else $error("sda pulled low too soon after scl fall");
    property p_sda_scl_high; sclIn && $past(sclIn) |-> $stable(sdaOeN); endproperty
    a_sda_scl_high: assert property (p_sda_scl_high)
        else $error("sda drive changed while scl high");
    property p_sda_od; sdaOut == 1'b0; endproperty
    a_sda_od: assert property (p_sda_od)
        else $error("sda drive value not low");
    property p_scl_od; sclOut == 1'b0; endproperty
    a_scl_od: assert property (p_scl_od)
        else $error("scl drive value not low");
    property p_dac_period; $changed(dacCode) |=> $stable(dacCode) [*5]; endproperty
    a_dac_period: assert property (p_dac_period)
        else $error("trial word changed inside one period");
    property p_dac_clk; $changed(dacCode) |-> $past(internalClkOn); endproperty
    a_dac_clk: assert property (p_dac_clk)
        else $error("trial word moved with clock off");
    property p_dac_pwr; $changed(dacCode) |-> $past(converterOn); endproperty
    a_dac_pwr: assert property (p_dac_pwr)
        else $error("trial word moved with converter off");
    property p_rst_idle;
        $fell(sys_rst) |-> sdaOeN && sclOeN && !referenceOn && !converterOn;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("outputs not idle after reset");
endmodule : aics_sva

// ==== sim/aics_i2c_master.sv ====
// i2c bus master model driving the converter control pins
`timescale 1ns/1ps
module aics_i2c_master (
    // clock
    input  wire logic clk,
    // open-drain enables from the device
    input  wire logic sclOeN,
    input  wire logic sdaOeN,
    // resolved bus levels
    output logic      sclIn,
    output logic      sdaIn
);
    logic sclM = 1'b1;
    logic sdaM = 1'b1;
    // wired-and with pull-ups, released lines read high
    assign sclIn = sclM & sclOeN;
    assign sdaIn = sdaM & sdaOeN;
    task automatic waitQ;
        repeat (20) @(posedge clk);
        #1;
    endtask : waitQ
    task automatic bitx(input logic v, output logic s);
        waitQ();
        sdaM = v;
        waitQ();
        sclM = 1'b1;
        // device may hold scl low while converting
        for (int k = 0; k < 400 && sclOeN !== 1'b1; k++) @(posedge clk);
        waitQ();
        s = sdaIn;
        waitQ();
        sclM = 1'b0;
    endtask : bitx
    task automatic start;
        waitQ();
        sdaM = 1'b0;
        waitQ();
        sclM = 1'b0;
    endtask : start
    task automatic stop;
        waitQ();
        sdaM = 1'b0;
        waitQ();
        sclM = 1'b1;
        waitQ();
        sdaM = 1'b1;
        waitQ();
    endtask : stop
    task automatic xfer(input logic [7:0] d, input logic ackM, output logic [7:0] r,
                        output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], b);
            r[i] = b;
        end
        bitx(ackM, ack);
    endtask : xfer
endmodule : aics_i2c_master

// ==== sim/adc_i2c_command_sar_tb.sv ====
// self-checking bench of the converter control top
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module adc_i2c_command_sar_tb;
    localparam logic [6:0] ADDR_A = {aics_pkg::ADDR_FIXED, 2'h2};
    localparam logic [6:0] ADDR_B = {aics_pkg::ADDR_FIXED, 2'h1};
    logic        clk, sysRst, addrPinHigh, addrPinLow, sclIn, sdaIn, sclOut, sclOeN;
    logic        sdaOut, sdaOeN, inputTypeSel, converterOn, referenceOn, internalClkOn;
    logic [7:0]  dacCode, cmd, r;
    logic [2:0]  channelSel;
    logic        a;
    int          failures, nTests, vin, expQ[$];
    bit   [31:0] seed = 32'h146DD;
    // analog comparator: high while input is at or above the trial level
    wire         cmpOut = (vin >= int'(dacCode));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    aics_top i_aics_top (.clk(clk), .sys_rst(sysRst), .clkEn(1'b1), .sclIn(sclIn),
        .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
        .addrPinHigh(addrPinHigh), .addrPinLow(addrPinLow), .cmpOut(cmpOut),
        .dacCode(dacCode), .inputTypeSel(inputTypeSel), .channelSel(channelSel),
        .converterOn(converterOn), .referenceOn(referenceOn), .internalClkOn(internalClkOn));
    aics_i2c_master i_aics_i2c_master (.clk(clk), .sclOeN(sclOeN), .sdaOeN(sdaOeN),
        .sclIn(sclIn), .sdaIn(sdaIn));
    function automatic bit [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift
    task automatic summarize;
        if (failures == 0 && nTests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    task automatic waitIdle;
        int k;
        for (k = 0; k < 400 && internalClkOn !== 1'b0; k++) begin
            @(posedge clk);
            #1;
        end
        if (k == 400) begin
            failures++;
            summarize();
        end
    endtask : waitIdle
    initial begin
        bit [31:0] x;
        int t;
        sysRst = 1'b1;
        {addrPinHigh, addrPinLow} = 2'h2;
        vin = 0;
        failures = 0;
        nTests = 0;
        repeat (16) @(posedge clk);
        #1 sysRst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            x = xorshift();
            cmd = {x[7:4], i[1:0], x[1:0]};
            @(posedge clk);
            #1 vin = int'(x[15:8]);
            t = 0;
            for (int b = 7; b >= 0; b--) begin
                t |= 1 << b;
                if (vin < t) t &= ~(1 << b);
            end
            expQ.push_back(t);
            i_aics_i2c_master.start();
            i_aics_i2c_master.xfer({ADDR_A, 1'b0}, 1'b1, r, a);
            `CHK(a, 1'b0)
            i_aics_i2c_master.xfer(cmd, 1'b1, r, a);
            `CHK(a, 1'b0)
            `CHK(inputTypeSel, cmd[7])
            `CHK(channelSel, cmd[6:4])
            `CHK(referenceOn, cmd[3])
            i_aics_i2c_master.stop();
            waitIdle();
            `CHK(converterOn, cmd[2])
            @(posedge clk);
            #1 {addrPinHigh, addrPinLow} = 2'h1;
            i_aics_i2c_master.start();
            i_aics_i2c_master.xfer({ADDR_A, 1'b1}, 1'b1, r, a);
            `CHK(a, 1'b0)
            i_aics_i2c_master.xfer(8'hFF, 1'b0, r, a);
            `CHK(r, 8'(expQ[0]))
            i_aics_i2c_master.xfer(8'hFF, 1'b1, r, a);
            `CHK(r, 8'(expQ.pop_front()))
            i_aics_i2c_master.stop();
            i_aics_i2c_master.start();
            i_aics_i2c_master.xfer({ADDR_B, 1'b1}, 1'b1, r, a);
            `CHK(a, 1'b1)
            i_aics_i2c_master.stop();
        end
        // high-speed master code is never acknowledged
        i_aics_i2c_master.start();
        i_aics_i2c_master.xfer(8'h08, 1'b1, r, a);
        `CHK(a, 1'b1)
        `CHK(sclOeN, 1'b1)
        i_aics_i2c_master.stop();
        summarize();
    end
endmodule : adc_i2c_command_sar_tb
bind aics_top aics_sva i_aics_sva (.clk(clk), .sys_rst(sys_rst), .sclIn(sclIn),
    .sclOut(sclOut), .sclOeN(sclOeN), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .dacCode(dacCode),
    .converterOn(converterOn), .referenceOn(referenceOn), .internalClkOn(internalClkOn));
